/* File: verilog/brtq_turnaround.sv */
// backward rm-cell turnaround queue with overflow policies
// What this block does
// R1: clumped arrivals leave in successive in-rate slots
// R2: latest mode uses counter plus one store
// R3: latest mode sends newest received contents
// R4: per-cell mode stores each queued entry
// R5: drop policy: discard head, append new
// R6: old policy: head out-of-rate, append new
// R7: per-cell newest-oor sent in-rate flushes queue
// R8: no out-of-rate cell before queue full
// R9: latest overflow: new out-of-rate, kept queued
// R10: non-queued: one pending set, latest, next slot
// R11: newest policy overwrites then sends out-of-rate
// R12: drop policy never sends out-of-rate
// R13: congestion bit taken at transmission
// R14: static configuration inputs, full at depth
// R15: grant takes one pending, empty grant nothing
`timescale 1ns/1ps
module brtq_turnaround (
    input  wire logic                        clk_i,
    input  wire logic                        reset_i,
    input  wire brtq_pkg::brtq_mode_type     queue_mode_i,
    input  wire brtq_pkg::brtq_policy_type   policy_i,
    input  wire logic [brtq_pkg::CNT_W-1:0]  depth_i,
    input  wire logic                        fwd_valid_i,
    input  wire logic [brtq_pkg::DATA_W-1:0] fwd_data_i,
    input  wire logic                        slot_i,
    input  wire logic                        ci_i,
    output logic                             ir_valid_o,
    output logic      [brtq_pkg::DATA_W-1:0] ir_data_o,
    output logic                             ir_ci_o,
    output logic                             oor_valid_o,
    output logic      [brtq_pkg::DATA_W-1:0] oor_data_o,
    output logic                             oor_ci_o,
    output logic      [brtq_pkg::CNT_W-1:0]  count_o,
    output logic                             full_o
);
    import brtq_pkg::*;

    // non-queued operation is a queue of one
    function automatic logic [CNT_W-1:0] eff_depth(
        input brtq_mode_type    mode,
        input logic [CNT_W-1:0] depth
    );
        logic [CNT_W-1:0] d;
        d = depth;
        if (mode == MODE_NONE || depth == CNT_ZERO) begin
            d = CNT_ONE;
        end else if (depth > DEPTH_CNT) begin
            d = DEPTH_CNT;
        end
        return d;
    endfunction : eff_depth

    logic [CNT_W-1:0]   count_r;
    logic [CNT_W-1:0]   count_nxt;
    logic [DATA_W-1:0]  latest_r;
    logic [DATA_W-1:0]  latest_nxt;
    logic               ir_valid_r;
    logic               ir_valid_nxt;
    logic [DATA_W-1:0]  ir_data_r;
    logic [DATA_W-1:0]  ir_data_nxt;
    logic               ir_ci_r;
    logic               ir_ci_nxt;
    logic               oor_valid_r;
    logic               oor_valid_nxt;
    logic [DATA_W-1:0]  oor_data_r;
    logic [DATA_W-1:0]  oor_data_nxt;
    logic               oor_ci_r;
    logic               oor_ci_nxt;

    logic [CNT_W-1:0]   depth_eff;
    logic               full;
    logic               percell;
    logic               take;
    logic               ovf;
    logic               push;
    logic               pop;
    logic               flush;
    logic               wmark;
    logic               inc;
    logic               dec;
    logic [ENTRY_W-1:0] head_q;
    logic [DATA_W-1:0]  head_data;
    logic               head_mark;

    assign depth_eff = eff_depth(queue_mode_i, depth_i); // R14
    assign full      = count_r >= depth_eff;               // R14
    assign percell   = queue_mode_i == MODE_PERCELL;
    assign take      = slot_i && count_r != CNT_ZERO;      // R15
    // a grant in the same cycle frees room, so no overflow then
    assign ovf       = fwd_valid_i && full && !take;       // R8
    assign head_data = head_q[DATA_W-1:0];
    assign head_mark = head_q[ENTRY_W-1];

    always_comb begin
        latest_nxt    = latest_r;
        ir_valid_nxt  = 1'b0;
        ir_data_nxt   = ir_data_r;
        ir_ci_nxt     = ir_ci_r;
        oor_valid_nxt = 1'b0;
        oor_data_nxt  = oor_data_r;
        oor_ci_nxt    = oor_ci_r;
        push          = 1'b0;
        pop           = 1'b0;
        flush         = 1'b0;
        wmark         = 1'b0;
        inc           = 1'b0;
        dec           = 1'b0;
        if (fwd_valid_i) begin
            latest_nxt = fwd_data_i;                       // R3 R10
            push       = percell;                          // R4
        end
        if (take) begin
            ir_valid_nxt = 1'b1;                           // R1 R10
            ir_data_nxt  = percell ? head_data : latest_r; // R2 R3 R4
            ir_ci_nxt    = ci_i;                           // R13
            dec          = 1'b1;                           // R15
            pop          = percell;
            flush        = percell && head_mark;           // R7
        end
        if (fwd_valid_i && !ovf) begin
            inc = 1'b1;
        end
        if (ovf) begin
            pop = percell;                                 // R5 R6
            case (policy_i)
                POL_DROP: begin
                    oor_valid_nxt = 1'b0;                  // R5 R12
                end
                POL_OLD_OOR: begin
                    oor_valid_nxt = 1'b1;                  // R6
                    oor_data_nxt  = percell ? head_data : latest_r;
                    oor_ci_nxt    = ci_i;                  // R13
                end
                POL_NEW_OOR: begin
                    oor_valid_nxt = 1'b1;                  // R9 R11
                    oor_data_nxt  = fwd_data_i;            // R11
                    oor_ci_nxt    = ci_i;                  // R13
                    wmark         = percell;               // R7
                end
                default: begin
                    oor_valid_nxt = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        count_nxt = count_r;
        if (flush) begin
            count_nxt = fwd_valid_i ? CNT_ONE : CNT_ZERO;  // R7
        end else if (inc && !dec) begin
            count_nxt = count_r + CNT_ONE;                 // R1
        end else if (dec && !inc) begin
            count_nxt = count_r - CNT_ONE;                 // R15
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_r     <= CNT_ZERO;
            latest_r    <= DATA_RST;
            ir_valid_r  <= 1'b0;
            ir_data_r   <= DATA_RST;
            ir_ci_r     <= 1'b0;
            oor_valid_r <= 1'b0;
            oor_data_r  <= DATA_RST;
            oor_ci_r    <= 1'b0;
        end else begin
            count_r     <= count_nxt;
            latest_r    <= latest_nxt;
            ir_valid_r  <= ir_valid_nxt;
            ir_data_r   <= ir_data_nxt;
            ir_ci_r     <= ir_ci_nxt;
            oor_valid_r <= oor_valid_nxt;
            oor_data_r  <= oor_data_nxt;
            oor_ci_r    <= oor_ci_nxt;
        end
    end

    brtq_store brtq_store_i (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .push_i  (push),
        .pop_i   (pop),
        .flush_i (flush),
        .wdata_i ({wmark, fwd_data_i}),
        .head_o  (head_q)
    );

    assign ir_valid_o  = ir_valid_r;
    assign ir_data_o   = ir_data_r;
    assign ir_ci_o     = ir_ci_r;
    assign oor_valid_o = oor_valid_r;
    assign oor_data_o  = oor_data_r;
    assign oor_ci_o    = oor_ci_r;
    assign count_o     = count_r;
    assign full_o      = full;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    oor_only_full_a: assert property ( // R8
        oor_valid_o |-> $past(full_o) && $past(fwd_valid_i)
    ) else $error("out-of-rate cell sent before queue full");

    drop_no_oor_a: assert property ( // R12
        policy_i == POL_DROP && $past(policy_i) == POL_DROP
            |-> !oor_valid_o
    ) else $error("drop policy produced out-of-rate cell");

    grant_dec_a: assert property ( // R15
        slot_i && count_o != CNT_ZERO && !fwd_valid_i && !flush
            |=> ir_valid_o && count_o == $past(count_o) - CNT_ONE
    ) else $error("slot grant did not take one pending cell");

    empty_grant_a: assert property ( // R15
        slot_i && count_o == CNT_ZERO |=> !ir_valid_o
    ) else $error("empty grant produced backward cell");

    clump_fill_a: assert property ( // R1
        fwd_valid_i && !full_o && !slot_i
            |=> count_o == $past(count_o) + CNT_ONE
    ) else $error("arrival below depth not queued");

    drop_hold_a: assert property ( // R5
        fwd_valid_i && full_o && !slot_i && policy_i == POL_DROP
            |=> count_o == $past(count_o) && !oor_valid_o
    ) else $error("drop overflow changed pending count");

    latest_data_a: assert property ( // R3
        slot_i && count_o != CNT_ZERO && queue_mode_i == MODE_LATEST
            |=> ir_data_o == $past(latest_r)
    ) else $error("latest mode sent stale contents");

    new_oor_a: assert property ( // R11
        ovf && policy_i == POL_NEW_OOR
            |=> oor_valid_o && oor_data_o == $past(fwd_data_i)
                && latest_r == $past(fwd_data_i)
                && count_o == $past(count_o)
    ) else $error("newest policy did not send new contents");

    old_oor_a: assert property ( // R6
        ovf && policy_i == POL_OLD_OOR && percell
            |=> oor_valid_o && oor_data_o == $past(head_data)
    ) else $error("old policy did not send queue head");

    ci_at_send_a: assert property ( // R13
        take |=> ir_valid_o && ir_ci_o == $past(ci_i)
    ) else $error("congestion bit not taken at send");

    count_bound_a: assert property ( // R14
        count_o <= depth_eff
    ) else $error("pending count above queue depth");

    ir_from_grant_a: assert property ( // R15
        ir_valid_o |-> $past(slot_i) && $past(count_o) != CNT_ZERO
    ) else $error("in-rate cell without pending grant");

    flush_empty_a: assert property ( // R7
        take && percell && head_mark && !fwd_valid_i
            |=> count_o == CNT_ZERO
    ) else $error("marked in-rate head did not flush queue");

    flush_keep_a: assert property ( // R7
        take && percell && head_mark && fwd_valid_i
            |=> count_o == CNT_ONE
    ) else $error("flush lost the arrival of the same cycle");

    grant_arrive_a: assert property ( // R15
        take && fwd_valid_i && !(percell && head_mark)
            |=> count_o == $past(count_o)
    ) else $error("grant with arrival changed pending count");

    percell_data_a: assert property ( // R4
        take && percell |=> ir_data_o == $past(head_data)
    ) else $error("per-cell mode did not send queue head");

    latest_store_a: assert property ( // R3
        fwd_valid_i |=> latest_r == $past(fwd_data_i)
    ) else $error("latest contents not updated by arrival");

    old_latest_a: assert property ( // R6
        ovf && policy_i == POL_OLD_OOR && !percell
            |=> oor_valid_o && oor_data_o == $past(latest_r)
    ) else $error("old policy did not send stored contents");

    old_count_a: assert property ( // R6
        ovf && policy_i == POL_OLD_OOR |=> count_o == $past(count_o)
    ) else $error("old policy changed pending count");

    oor_ci_a: assert property ( // R13
        ovf && (policy_i == POL_OLD_OOR || policy_i == POL_NEW_OOR)
            |=> oor_ci_o == $past(ci_i)
    ) else $error("congestion bit not taken at out-of-rate send");

    no_early_oor_a: assert property ( // R8
        !(fwd_valid_i && full_o) |=> !oor_valid_o
    ) else $error("out-of-rate cell without full arrival");

    none_single_a: assert property ( // R10
        queue_mode_i == MODE_NONE |-> count_o <= CNT_ONE
    ) else $error("non-queued mode holds more than one set");

endmodule : brtq_turnaround

/* File: verilog/brtq_pkg.sv */
// constants and types for the backward rm-cell turnaround queue
package brtq_pkg;

    localparam int DATA_W  = 32;
    localparam int ENTRY_W = DATA_W + 1;
    localparam int DEPTH   = 8;
    localparam int CNT_W   = 4;
    localparam int PTR_W   = 3;

    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 4'h8;
    localparam logic [PTR_W-1:0] PTR_ZERO  = 3'h0;
    localparam logic [PTR_W-1:0] PTR_ONE   = 3'h1;

    localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
    localparam logic [ENTRY_W-1:0] ENTRY_RST = 33'h0_0000_0000;

    // queue organisation
    typedef enum logic [1:0] {
        MODE_NONE    = 2'b00,
        MODE_LATEST  = 2'b01,
        MODE_PERCELL = 2'b10
    } brtq_mode_type;

    // handling of an arrival at a full queue
    typedef enum logic [1:0] {
        POL_DROP    = 2'b00,
        POL_OLD_OOR = 2'b01,
        POL_NEW_OOR = 2'b10
    } brtq_policy_type;

endpackage : brtq_pkg

/* File: verilog/brtq_store.sv */
// circular storage of per-cell queue entries
`timescale 1ns/1ps
module brtq_store (
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         push_i,
    input  wire logic                         pop_i,
    input  wire logic                         flush_i,
    input  wire logic [brtq_pkg::ENTRY_W-1:0] wdata_i,
    output logic      [brtq_pkg::ENTRY_W-1:0] head_o
);
    import brtq_pkg::*;

    logic [ENTRY_W-1:0] mem_r   [DEPTH];
    logic [ENTRY_W-1:0] mem_nxt [DEPTH];
    logic [PTR_W-1:0]   head_r;
    logic [PTR_W-1:0]   head_nxt;
    logic [PTR_W-1:0]   tail_r;
    logic [PTR_W-1:0]   tail_nxt;

    always_comb begin
        mem_nxt  = mem_r;
        tail_nxt = tail_r;
        head_nxt = head_r;
        if (push_i) begin
            mem_nxt[tail_r] = wdata_i;
            tail_nxt        = tail_r + PTR_ONE;
        end
        // flush keeps only an entry written in the same cycle
        if (flush_i) begin
            head_nxt = tail_r;
        end else if (pop_i) begin
            head_nxt = head_r + PTR_ONE;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            head_r <= PTR_ZERO;
            tail_r <= PTR_ZERO;
        end else begin
            head_r <= head_nxt;
            tail_r <= tail_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        mem_r <= mem_nxt;
    end

    assign head_o = mem_r[head_r];

endmodule : brtq_store

/* File: tb/brtq_net_model.sv */
// network model: forward cells, backward slots and congestion state
`timescale 1ns/1ps
module brtq_net_model (
    input  wire logic                    clk_i,
    output logic                         fwd_valid_o,
    output logic [brtq_pkg::DATA_W-1:0]  fwd_data_o,
    output logic                         slot_o,
    output logic                         ci_o
);
    import brtq_pkg::*;
    initial begin
        fwd_valid_o = 1'b0;
        fwd_data_o  = DATA_RST;
        slot_o      = 1'b0;
        ci_o        = 1'b0;
    end
    // one cycle of traffic; idle data flips, so it differs from the word of the cycle before
    task cycle(input logic f, input logic [DATA_W-1:0] d,
               input logic s, input logic c);
        @(negedge clk_i);
        fwd_valid_o = f;
        fwd_data_o  = f ? d : ~fwd_data_o;
        slot_o      = s;
        ci_o        = c;
    endtask : cycle
endmodule : brtq_net_model

/* File: tb/testbench.sv */
// testbench for the backward rm-cell turnaround queue
`timescale 1ns/1ps
module testbench;
    import brtq_pkg::*;
    localparam logic [31:0] CA = 32'hA5A5_0001;
    localparam logic [31:0] CB = 32'h5A5A_0002;
    localparam logic [31:0] CC = 32'hC3C3_0003;
    localparam logic [31:0] CD = 32'h3C3C_0004;
    logic                  clk_i;
    logic                  reset_i;
    brtq_mode_type         mode;
    brtq_policy_type       pol;
    logic [CNT_W-1:0]      depth;
    logic                  fwd_valid;
    logic [DATA_W-1:0]     fwd_data;
    logic                  slot;
    logic                  ci;
    logic                  ir_valid;
    logic [DATA_W-1:0]     ir_data;
    logic                  ir_ci;
    logic                  oor_valid;
    logic [DATA_W-1:0]     oor_data;
    logic                  oor_ci;
    logic [CNT_W-1:0]      count;
    logic                  full;
    logic [DATA_W:0]       ir_q[$];
    logic [DATA_W:0]       oor_q[$];
    int                    num_errors;
    int                    checks;

    brtq_net_model brtq_net_model_i (.clk_i(clk_i), .fwd_valid_o(fwd_valid),
        .fwd_data_o(fwd_data), .slot_o(slot), .ci_o(ci));
    brtq_turnaround brtq_turnaround_i (.clk_i(clk_i), .reset_i(reset_i),
        .queue_mode_i(mode), .policy_i(pol), .depth_i(depth),
        .fwd_valid_i(fwd_valid), .fwd_data_i(fwd_data), .slot_i(slot),
        .ci_i(ci), .ir_valid_o(ir_valid), .ir_data_o(ir_data),
        .ir_ci_o(ir_ci), .oor_valid_o(oor_valid), .oor_data_o(oor_data),
        .oor_ci_o(oor_ci), .count_o(count), .full_o(full));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // collect every backward cell with its congestion bit
    always @(negedge clk_i) begin
        if (ir_valid === 1'b1) ir_q.push_back({ir_ci, ir_data});
        if (oor_valid === 1'b1) oor_q.push_back({oor_ci, oor_data});
    end

    task check(input string n, input logic [39:0] s, input logic [39:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task stop_test;
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task restart(input brtq_mode_type m, input brtq_policy_type p,
                 input logic [CNT_W-1:0] d);
        @(negedge clk_i);
        reset_i = 1'b1;
        mode = m;
        pol = p;
        depth = d;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        ir_q.delete();
        oor_q.delete();
    endtask : restart
    task idle(input int n);
        repeat (n) brtq_net_model_i.cycle(1'b0, DATA_RST, 1'b0, 1'b0);
    endtask : idle
    task send(input logic [DATA_W-1:0] d);
        brtq_net_model_i.cycle(1'b1, d, 1'b0, 1'b0);
    endtask : send
    task grant(input logic c);
        brtq_net_model_i.cycle(1'b0, DATA_RST, 1'b1, c);
    endtask : grant

    task test_latest;
        restart(MODE_LATEST, POL_DROP, 4'h4);
        send(CA); send(CB); send(CC); idle(1);
        check("count", count, 3);
        grant(1'b1); grant(1'b0); grant(1'b1); grant(1'b0); idle(3);
        check("count", count, 0);
        check("nir", ir_q.size(), 3);
        check("ir0", ir_q[0], {1'b1, CC});
        check("ir1", ir_q[1], {1'b0, CC});
        check("ir2", ir_q[2], {1'b1, CC});
        check("noor", oor_q.size(), 0);
    endtask : test_latest
    task test_drop;
        restart(MODE_PERCELL, POL_DROP, 4'h2);
        send(CA); send(CB); idle(1);
        check("full", full, 1);
        send(CC); idle(1);
        check("count", count, 2);
        grant(1'b0); grant(1'b0); grant(1'b0); idle(3);
        check("ir0", ir_q[0], {1'b0, CB});
        check("ir1", ir_q[1], {1'b0, CC});
        check("nir", ir_q.size(), 2);
        check("noor", oor_q.size(), 0);
    endtask : test_drop
    task test_old;
        restart(MODE_PERCELL, POL_OLD_OOR, 4'h2);
        send(CA); send(CB); send(CC); idle(3);
        check("noor", oor_q.size(), 1);
        check("oor0", oor_q[0], {1'b0, CA});
        grant(1'b0); grant(1'b0); idle(3);
        check("ir0", ir_q[0], {1'b0, CB});
        check("ir1", ir_q[1], {1'b0, CC});
    endtask : test_old
    task test_old_latest;
        restart(MODE_LATEST, POL_OLD_OOR, 4'h2);
        send(CA);
        send(CB);
        send(CC);
        idle(3);
        check("oor0", oor_q[0], {1'b0, CB});
        check("count", count, 2);
        grant(1'b0);
        grant(1'b0);
        idle(3);
        check("ir0", ir_q[0], {1'b0, CC});
        check("nir", ir_q.size(), 2);
    endtask : test_old_latest
    task test_new_latest;
        restart(MODE_LATEST, POL_NEW_OOR, 4'h2);
        send(CA); send(CB); send(CC); idle(3);
        check("oor0", oor_q[0], {1'b0, CC});
        check("count", count, 2);
        grant(1'b0); grant(1'b0); idle(3);
        check("ir1", ir_q[1], {1'b0, CC});
    endtask : test_new_latest
    task test_flush;
        restart(MODE_PERCELL, POL_NEW_OOR, 4'h2);
        send(CA); send(CB); send(CC); idle(1);
        grant(1'b0); send(CD); grant(1'b0); grant(1'b0); idle(3);
        check("oor0", oor_q[0], {1'b0, CC});
        check("ir1", ir_q[1], {1'b0, CC});
        check("nir", ir_q.size(), 2);
        check("count", count, 0);
    endtask : test_flush
    task test_none;
        restart(MODE_NONE, POL_NEW_OOR, 4'h0);
        send(CA);
        brtq_net_model_i.cycle(1'b1, CB, 1'b0, 1'b1);
        idle(1);
        grant(1'b1); idle(3);
        check("oor0", oor_q[0], {1'b1, CB});
        check("ir0", ir_q[0], {1'b1, CB});
    endtask : test_none

    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        reset_i = 1'b1;
        mode = MODE_LATEST;
        pol = POL_DROP;
        depth = 4'h4;
        num_errors = 0;
        checks = 0;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        test_latest();
        test_drop();
        test_old();
        test_old_latest();
        test_new_latest();
        test_flush();
        test_none();
        stop_test();
    end
endmodule : testbench
